// >>> rtl/ecm_unit.sv
// mode decode, capture/compare pin logic and PWM output assignment of the enhanced unit
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`include "ecm_map.svh"

module ecm_unit #(
  parameter int TIMER_W = 16
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [TIMER_W-1:0] first_timer_pair,
  input  wire logic [TIMER_W-1:0] third_timer_pair,
  input  wire logic               timer_match,
  input  wire logic               capture_in,
  input  wire logic               pwm_period_start,
  input  wire logic               pwm_mod,
  input  wire logic               pwm_mod_comp,
  output logic      [9:0]         duty_value,
  output logic                    first_timer_reset,
  output logic                    third_timer_reset,
  output logic                    pwm_out_a,
  output logic                    pwm_out_b,
  output logic                    pwm_out_c,
  output logic                    pwm_out_d,
  output logic                    pwm_oe_a,
  output logic                    pwm_oe_b,
  output logic                    pwm_oe_c,
  output logic                    pwm_oe_d,
  output logic                    irq
);
  import ecm_pkg::*;

  // ============================================================
  // elaboration checks
  if (TIMER_W < 8 || TIMER_W > 32)
  begin : g_bad_width
    $error("TIMER_W must lie in 8..32");
  end

  // ============================================================
  // state
  logic [7:0]         ctrl_q;
  logic [7:0]         dutyh_q;
  logic               tsel_q;
  logic [3:0]         steer_q;
  logic [1:0]         stat_q;
  logic [1:0]         mask_q;
  logic [TIMER_W-1:0] capt_q;
  logic [3:0]         prev_mode_q;
  logic               cap_prev_q;
  logic [3:0]         presc_q;
  logic               pin_q;
  logic               armed_q;
  logic [31:0]        rd_d;
  logic               mapped;

  ecm_mode_t   mode;
  ecm_bridge_t bridge;
  logic        pwm_mode;
  logic        entered;
  logic        wr_en;
  logic        rise;
  logic        fall;
  logic        cap_evt;
  logic        cmp_evt;
  logic        spec_evt;

  // level on a pin from its active state and its polarity
  function automatic logic lvl(input logic act, input logic low);
    return act ^ low;
  endfunction

  assign mode     = ecm_mode_t'(ctrl_q[`ECM_CTRL_MODE]);
  assign bridge   = ecm_bridge_t'(ctrl_q[`ECM_CTRL_BRIDGE]);
  assign pwm_mode = (ctrl_q[3:2] == 2'b11);                  // R15
  assign entered  = (ctrl_q[3:0] != prev_mode_q);
  assign wr_en    = psel && penable && pready && pwrite;
  assign rise     = capture_in && !cap_prev_q;
  assign fall     = !capture_in && cap_prev_q;

  // ============================================================
  // event decode; timers and their match live outside
  always_comb
  begin
    cap_evt = 1'b0;
    case (mode)
      MODE_CAP_FALL: cap_evt = fall;                            // R9
      MODE_CAP_RISE: cap_evt = rise;                            // R9
      MODE_CAP_4:    cap_evt = rise && (presc_q == `ECM_PRESC_LAST4);  // R10
      MODE_CAP_16:   cap_evt = rise && (presc_q == `ECM_PRESC_LAST16); // R10
      default:       cap_evt = 1'b0;
    endcase
  end

  // reserved codes 0001/0011 deliberately do nothing
  assign cmp_evt  = timer_match && (mode == MODE_TOGGLE || ctrl_q[3:2] == 2'b10); // R19
  assign spec_evt = timer_match && (mode == MODE_CMP_SPEC);  // R14

  // ============================================================
  // apb slave: one wait state, data and error launched with pready
  always_comb
  begin
    rd_d   = 32'h0;
    mapped = 1'b1;
    case (paddr)
      `ECM_OFF_CTRL: rd_d = {24'h0, ctrl_q};
      `ECM_OFF_DUTY: rd_d = {24'h0, dutyh_q};
      `ECM_OFF_CFG:  rd_d = {24'h0, steer_q, 3'h0, tsel_q};
      `ECM_OFF_STAT: rd_d = {30'h0, stat_q};
      `ECM_OFF_MASK: rd_d = {30'h0, mask_q};
      `ECM_OFF_CAPT: rd_d = 32'(capt_q);
      default:       mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && penable && !pready;
      prdata  <= (psel && penable && !pready && !pwrite) ? rd_d : 32'h0;
      pslverr <= psel && penable && !pready && !mapped;
    end
  end

  // ============================================================
  // software registers; writing zero to control releases the pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q  <= `ECM_CTRL_RST;
      dutyh_q <= `ECM_DUTY_RST;
      tsel_q  <= 1'b0;
      steer_q <= `ECM_STEER_RST;
      mask_q  <= 2'h0;
    end
    else if (wr_en)
    begin
      case (paddr)
        `ECM_OFF_CTRL: ctrl_q <= pwdata[7:0];                // R18
        `ECM_OFF_DUTY: dutyh_q <= pwdata[7:0];
        `ECM_OFF_CFG:
        begin
          tsel_q  <= pwdata[`ECM_CFG_TSEL];
          steer_q <= pwdata[`ECM_CFG_STEER];
        end
        `ECM_OFF_MASK: mask_q <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_q <= `ECM_STAT_RST;
    else
    begin
      stat_q[`ECM_ST_EVENT] <= (cap_evt || cmp_evt) ||
        (stat_q[`ECM_ST_EVENT] && !(wr_en && paddr == `ECM_OFF_STAT && pwdata[`ECM_ST_EVENT])); // R11
      stat_q[`ECM_ST_SPECIAL] <= spec_evt ||
        (stat_q[`ECM_ST_SPECIAL] && !(wr_en && paddr == `ECM_OFF_STAT && pwdata[`ECM_ST_SPECIAL])); // R14
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(stat_q & mask_q);
  end

  // ============================================================
  // capture path: edge history, prescaler and captured value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_mode_q <= 4'h0;
      cap_prev_q  <= 1'b0;
      presc_q     <= 4'h0;
      capt_q      <= '0;
    end
    else
    begin
      prev_mode_q <= ctrl_q[3:0];
      cap_prev_q  <= capture_in;
      // a mode change restarts the prescaler so old edges are not counted
      if (mode == MODE_OFF || entered)
        presc_q <= 4'h0;                                     // R7
      else if (cap_evt)
        presc_q <= 4'h0;                                     // R10
      else if (rise && (mode == MODE_CAP_4 || mode == MODE_CAP_16))
        presc_q <= presc_q + 4'h1;                           // R10
      if (cap_evt)
        capt_q <= tsel_q ? third_timer_pair : first_timer_pair; // R9
    end
  end

  // ============================================================
  // compare pin state and special event trigger
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_q             <= 1'b0;
      first_timer_reset <= 1'b0;
      third_timer_reset <= 1'b0;
    end
    else
    begin
      first_timer_reset <= spec_evt && !tsel_q;              // R14
      third_timer_reset <= spec_evt && tsel_q;               // R14
      case (mode)
        MODE_OFF:     pin_q <= 1'b0;                         // R7
        MODE_TOGGLE:  pin_q <= timer_match ? !pin_q : pin_q; // R8
        MODE_CMP_SET: pin_q <= entered ? 1'b0 : (pin_q || timer_match);  // R11
        MODE_CMP_CLR: pin_q <= entered ? 1'b1 : (pin_q && !timer_match); // R12
        default:      pin_q <= pin_q;
      endcase
    end
  end

  // ============================================================
  // pwm start: waveform only after the next period boundary
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      armed_q <= 1'b0;
    else if (!pwm_mode)
      armed_q <= 1'b0;                                       // R17
    else if (pwm_period_start)
      armed_q <= 1'b1;                                       // R17
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      duty_value <= 10'h0;
    else if (pwm_mode)
      duty_value <= {dutyh_q, ctrl_q[`ECM_CTRL_DLOW]};       // R6
  end

  // ============================================================
  // output assignment; in pwm modes until armed every enabled pin sits at its inactive level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d} <= 4'h0;
      {pwm_oe_a, pwm_oe_b, pwm_oe_c, pwm_oe_d}     <= 4'h0;
    end
    else if (!pwm_mode)
    begin
      // unit pin driven only by the compare modes that own it
      pwm_out_a <= pin_q;                                    // R1
      pwm_oe_a  <= (mode == MODE_TOGGLE || mode == MODE_CMP_SET ||
                    mode == MODE_CMP_CLR);                   // R13
      {pwm_out_b, pwm_out_c, pwm_out_d} <= 3'h0;
      {pwm_oe_b, pwm_oe_c, pwm_oe_d}    <= 3'h0;             // R1
    end
    else
    begin
      case (bridge)
        BR_SINGLE:
        begin
          pwm_out_a <= lvl(armed_q && pwm_mod, ctrl_q[1]);   // R2
          pwm_out_b <= lvl(armed_q && pwm_mod, ctrl_q[0]);
          pwm_out_c <= lvl(armed_q && pwm_mod, ctrl_q[1]);
          pwm_out_d <= lvl(armed_q && pwm_mod, ctrl_q[0]);
          {pwm_oe_d, pwm_oe_c, pwm_oe_b, pwm_oe_a} <= steer_q; // R2
        end
        BR_FWD:
        begin
          pwm_out_a <= lvl(armed_q, ctrl_q[1]);              // R3
          pwm_out_b <= lvl(1'b0, ctrl_q[0]);
          pwm_out_c <= lvl(1'b0, ctrl_q[1]);
          pwm_out_d <= lvl(armed_q && pwm_mod, ctrl_q[0]);   // R3
          {pwm_oe_a, pwm_oe_b, pwm_oe_c, pwm_oe_d} <= 4'hf;
        end
        BR_HALF:
        begin
          // dead band is already applied to the complement upstream
          pwm_out_a <= lvl(armed_q && pwm_mod, ctrl_q[1]);   // R4
          pwm_out_b <= lvl(armed_q && pwm_mod_comp, ctrl_q[0]); // R4
          {pwm_out_c, pwm_out_d} <= 2'h0;
          {pwm_oe_a, pwm_oe_b, pwm_oe_c, pwm_oe_d} <= 4'hc;  // R4
        end
        default:
        begin
          pwm_out_a <= lvl(1'b0, ctrl_q[1]);                 // R5
          pwm_out_b <= lvl(armed_q && pwm_mod, ctrl_q[0]);   // R5
          pwm_out_c <= lvl(armed_q, ctrl_q[1]);              // R5
          pwm_out_d <= lvl(1'b0, ctrl_q[0]);
          {pwm_oe_a, pwm_oe_b, pwm_oe_c, pwm_oe_d} <= 4'hf;
        end
      endcase
    end
  end

  // ============================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rev_armed;
    pwm_mode && armed_q && bridge == BR_REV;
  endsequence

  property p_release;
    !pwm_mode |=> !pwm_oe_b && !pwm_oe_c && !pwm_oe_d;
  endproperty
  a_release: assert property (p_release) else $error("B-D not released"); // R1

  property p_fwd;
    pwm_mode && armed_q && bridge == BR_FWD && !ctrl_q[1] |=> pwm_out_a && !pwm_out_c;
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward levels wrong"); // R3

  property p_half;
    pwm_mode && bridge == BR_HALF |=> !pwm_oe_c && !pwm_oe_d && pwm_oe_a && pwm_oe_b;
  endproperty
  a_half: assert property (p_half) else $error("half bridge enables wrong"); // R4

  property p_rev;
    s_rev_armed ##0 (ctrl_q[1:0] == 2'b00) |=> pwm_out_c && !pwm_out_a && !pwm_out_d;
  endproperty
  a_rev: assert property (p_rev) else $error("reverse levels wrong"); // R5

  property p_duty;
    pwm_mode ##1 pwm_mode && $stable(ctrl_q) && $stable(dutyh_q)
      |-> duty_value == {dutyh_q, ctrl_q[5:4]};
  endproperty
  a_duty: assert property (p_duty) else $error("duty value wrong"); // R6

  property p_toggle;
    mode == MODE_TOGGLE && !entered && timer_match |=> pin_q != $past(pin_q);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle missed"); // R8

  // checked against the flag and the count, not the decode it would mirror
  property p_cap16;
    mode == MODE_CAP_16 && !entered && rise && presc_q != 4'hf
      |=> !$rose(stat_q[`ECM_ST_EVENT]) && presc_q == $past(presc_q) + 4'h1;
  endproperty
  a_cap16: assert property (p_cap16) else $error("early capture"); // R10

  property p_special;
    spec_evt && tsel_q |=> third_timer_reset && !first_timer_reset ##1 !third_timer_reset || $past(spec_evt);
  endproperty
  a_special: assert property (p_special) else $error("special trigger wrong"); // R14

  property p_hold_off;
    pwm_mode && !armed_q && !pwm_period_start && bridge == BR_SINGLE
      |=> pwm_out_a == $past(ctrl_q[1]);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("partial pulse"); // R17

  property p_off;
    mode == MODE_OFF |=> presc_q == 4'h0 && !armed_q ##1 !pwm_oe_a || $past(mode) != MODE_OFF;
  endproperty
  a_off: assert property (p_off) else $error("off did not reset"); // R7

endmodule // ecm_unit

// >>> rtl/ecm_map.svh
// register map, field positions and reset values of the enhanced capture unit mode control
`ifndef ECM_MAP_SVH
`define ECM_MAP_SVH
// What this block does
// R1: non-PWM modes: A is unit pin, B-D released
// R2: bridge 00: single output, steering picks pins
// R3: bridge 01: D modulated, A active, B/C inactive
// R4: bridge 10: A/B complementary, C/D released
// R5: bridge 11: B modulated, C active, A/D inactive
// R6: duty value is duty high byte plus two low bits
// R7: mode 0000 off and resets; 0001/0011 reserved
// R8: mode 0010 toggles pin on each match
// R9: 0100 captures falling edges, 0101 rising edges
// R10: 0110 every 4th rise, 0111 every 16th
// R11: 1000 pin low on entry, high on match
// R12: 1001 pin high on entry, low on match
// R13: 1010 flag only, pin left to port
// R14: 1011 special trigger resets selected timer, flags
// R15: 11xx PWM; bit1 inverts A/C, bit0 inverts B/D
// R16: software sets modes and pin directions first
// R17: PWM waits for new period before driving waveform
// R18: control register zero releases every PWM pin
// R19: timer values and match events come from outside

// ============================================================
// register byte offsets
`define ECM_OFF_CTRL      8'h00
`define ECM_OFF_DUTY      8'h04
`define ECM_OFF_CFG       8'h08
`define ECM_OFF_STAT      8'h0c
`define ECM_OFF_MASK      8'h10
`define ECM_OFF_CAPT      8'h14

// ============================================================
// field positions
`define ECM_CTRL_MODE     3:0
`define ECM_CTRL_DLOW     5:4
`define ECM_CTRL_BRIDGE   7:6
`define ECM_CFG_TSEL      0
`define ECM_CFG_STEER     7:4
`define ECM_ST_EVENT      0
`define ECM_ST_SPECIAL    1

// ============================================================
// reset values and counts
`define ECM_CTRL_RST      8'h00
`define ECM_DUTY_RST      8'h00
`define ECM_STEER_RST     4'h1
`define ECM_STAT_RST      2'h0
`define ECM_PRESC_LAST4   4'h3
`define ECM_PRESC_LAST16  4'hf
`endif

// >>> rtl/ecm_pkg.sv
// types shared by the enhanced capture unit mode control
package ecm_pkg;

  // unit mode select encodings
  typedef enum logic [3:0] {
    MODE_OFF     = 4'h0,
    MODE_RSV1    = 4'h1,
    MODE_TOGGLE  = 4'h2,
    MODE_RSV3    = 4'h3,
    MODE_CAP_FALL = 4'h4,
    MODE_CAP_RISE = 4'h5,
    MODE_CAP_4   = 4'h6,
    MODE_CAP_16  = 4'h7,
    MODE_CMP_SET = 4'h8,
    MODE_CMP_CLR = 4'h9,
    MODE_CMP_SW  = 4'ha,
    MODE_CMP_SPEC = 4'hb,
    MODE_PWM_HH  = 4'hc,
    MODE_PWM_HL  = 4'hd,
    MODE_PWM_LH  = 4'he,
    MODE_PWM_LL  = 4'hf
  } ecm_mode_t;

  // bridge output configuration encodings
  typedef enum logic [1:0] {
    BR_SINGLE = 2'h0,
    BR_FWD    = 2'h1,
    BR_HALF   = 2'h2,
    BR_REV    = 2'h3
  } ecm_bridge_t;

endpackage

// >>> verification/ecm_far_side.sv
// far-side model: two timer pairs and the modulated waveform source
`timescale 1ns/1ns

module ecm_far_side (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  input  wire logic        mod_lvl,
  input  wire logic        first_timer_reset,
  input  wire logic        third_timer_reset,
  output logic      [15:0] first_timer_pair,
  output logic      [15:0] third_timer_pair,
  output logic             pwm_mod,
  output logic             pwm_mod_comp
);
  // ============================================================
  // timers
  // timers stand still between loads and timer resets so captured values are predictable
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      first_timer_pair <= 16'h0000;
      third_timer_pair <= 16'h0000;
    end
    else if (load)
    begin
      first_timer_pair <= load_val;
      third_timer_pair <= ~load_val;
    end
    else
    begin
      if (first_timer_reset)
        first_timer_pair <= 16'h0000;
      if (third_timer_reset)
        third_timer_pair <= 16'h0000;
    end

  // ============================================================
  // waveform
  // dead band lives in the real generator, so the complement here is ideal
  assign pwm_mod      = mod_lvl;
  assign pwm_mod_comp = ~mod_lvl;
endmodule // ecm_far_side

// >>> verification/ecm_unit_bench.sv
// self-checking bench for the enhanced unit mode control
`timescale 1ns/1ns
`include "ecm_map.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR %s exp %h got %h", nm, e, g); end end

module ecm_unit_bench;
  import ecm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] t1, t3, load_val;
  logic        timer_match, capture_in, period, mod_lvl, pm, pmc, load;
  logic [9:0]  duty_value;
  logic        r1, r3, oa, ob, oc, od, ea, eb, ec, ed, irq;
  logic [7:0]  pin;
  int          checked, n_mismatch;

  assign pin = {ed, ec, eb, ea, {od, oc, ob, oa} & {ed, ec, eb, ea}};

  ecm_unit ecm_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_timer_pair(t1), .third_timer_pair(t3), .timer_match(timer_match), .capture_in(capture_in),
    .pwm_period_start(period), .pwm_mod(pm), .pwm_mod_comp(pmc), .duty_value(duty_value),
    .first_timer_reset(r1), .third_timer_reset(r3), .pwm_out_a(oa), .pwm_out_b(ob), .pwm_out_c(oc),
    .pwm_out_d(od), .pwm_oe_a(ea), .pwm_oe_b(eb), .pwm_oe_c(ec), .pwm_oe_d(ed), .irq(irq));

  ecm_far_side ecm_far_side_i (.pclk(pclk), .presetn(presetn), .load(load), .load_val(load_val),
    .mod_lvl(mod_lvl), .first_timer_reset(r1), .third_timer_reset(r3), .first_timer_pair(t1),
    .third_timer_pair(t3), .pwm_mod(pm), .pwm_mod_comp(pmc));

  // ============================================================
  // clock and watchdog
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // whole run is well under a thousand cycles; this leaves ample margin
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    end_of_test();
  end

  // ============================================================
  // tasks
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer; a release edge follows so the next setup never lands in the same step
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
      n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b1, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input string nm);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b0, 32'h0, r, e);
    `CHK(nm, ex, r)
  endtask

  task automatic match();
    timer_match <= 1'b1;
    tick(1);
    timer_match <= 1'b0;
    tick(4);
  endtask

  task automatic ld(input logic [15:0] v);
    load_val <= v;
    load <= 1'b1;
    tick(1);
    load <= 1'b0;
    tick(1);
  endtask

  task automatic rises(input int n);
    repeat (n)
    begin
      capture_in <= 1'b1;
      tick(2);
      capture_in <= 1'b0;
      tick(2);
    end
  endtask

  // expected {enables, driven levels} for a pwm mode once armed
  function automatic logic [7:0] exp_pwm(input logic [1:0] br, input logic [1:0] pol, input logic m);
    logic [3:0] e;
    logic [3:0] o;
    case (br)
      2'h0: {e, o} = {4'h1, 3'h0, m};
      2'h1: {e, o} = {4'hf, m, 3'h1};
      2'h2: {e, o} = {4'h3, 2'h0, ~m, m};
      default: {e, o} = {4'hf, 2'h1, m, 1'b0};
    endcase
    return {e, (o ^ {pol[0], pol[1], pol[0], pol[1]}) & e};
  endfunction

  // ============================================================
  // main sequence
  initial
  begin
    logic [31:0] r;
    logic        e;
    logic        t;
    {psel, penable, pwrite, paddr, pwdata, timer_match, capture_in, period, mod_lvl, load} = '0;
    load_val = 16'h0000;
    checked = 0;
    n_mismatch = 0;
    presetn = 1'b0;
    tick(2);
    presetn <= 1'b1;
    tick(1);
    rdc(`ECM_OFF_CTRL, 32'h0, "ctrl reset");
    rdc(`ECM_OFF_DUTY, 32'h0, "duty reset");
    rdc(`ECM_OFF_CFG, 32'h10, "cfg reset");
    rdc(`ECM_OFF_STAT, 32'h0, "stat reset");
    rdc(`ECM_OFF_MASK, 32'h0, "mask reset");
    apb(8'h18, 1'b0, 32'h0, r, e);
    `CHK("unmapped", {1'b1, 32'h0}, {e, r})
    // bridge field set but ignored outside pwm modes
    wr(`ECM_OFF_CTRL, {24'h0, 4'hc, MODE_TOGGLE});
    tick(3);
    `CHK("toggle oe", 4'h1, pin[7:4])
    t = oa;
    match();
    `CHK("toggle pin", ~t, oa)
    for (int k = 0; k < 4; k++)
      if (k != 2)
      begin
        wr(`ECM_OFF_CTRL, k);
        wr(`ECM_OFF_STAT, 32'h3);
        match();
        `CHK("off oe", 4'h0, pin[7:4])
        rdc(`ECM_OFF_STAT, 32'h0, "off stat");
      end
    for (int k = 0; k < 2; k++)
    begin
      wr(`ECM_OFF_CTRL, 8 + k);
      tick(3);
      `CHK("entry pin", {1'b1, k[0]}, {pin[4], pin[0]})
      wr(`ECM_OFF_STAT, 32'h3);
      match();
      `CHK("match pin", {1'b1, ~k[0]}, {pin[4], pin[0]})
      rdc(`ECM_OFF_STAT, 32'h1, "cmp stat");
    end
    wr(`ECM_OFF_CTRL, MODE_CMP_SW);
    wr(`ECM_OFF_STAT, 32'h3);
    match();
    `CHK("sw oe", 1'b0, pin[4])
    rdc(`ECM_OFF_STAT, 32'h1, "sw stat");
    wr(`ECM_OFF_CTRL, MODE_CMP_SPEC);
    for (int k = 0; k < 2; k++)
    begin
      wr(`ECM_OFF_CFG, 32'h10 | k);
      ld(16'h1234);
      wr(`ECM_OFF_STAT, 32'h3);
      match();
      `CHK("timers", k ? 32'h12340000 : 32'h0000edcb, {t1, t3})
      rdc(`ECM_OFF_STAT, 32'h3, "spec stat");
    end
    wr(`ECM_OFF_MASK, 32'h2);
    tick(3);
    `CHK("irq on", 1'b1, irq)
    wr(`ECM_OFF_STAT, 32'h2);
    tick(3);
    `CHK("irq off", 1'b0, irq)
    rdc(`ECM_OFF_STAT, 32'h1, "w1c");
    // capture on the edge kinds, then the prescaled counts
    wr(`ECM_OFF_CFG, 32'h10);
    ld(16'h00ab);
    for (int k = 0; k < 2; k++)
    begin
      wr(`ECM_OFF_CTRL, 4 + k);
      wr(`ECM_OFF_STAT, 32'h3);
      capture_in <= ~k[0];
      tick(3);
      rdc(`ECM_OFF_STAT, 32'h0, "wrong edge");
      capture_in <= k[0];
      tick(3);
      rdc(`ECM_OFF_STAT, 32'h1, "edge stat");
      rdc(`ECM_OFF_CAPT, 32'hab, "capt");
      capture_in <= 1'b0;
      tick(2);
    end
    for (int k = 0; k < 2; k++)
    begin
      wr(`ECM_OFF_CTRL, 6 + k);
      wr(`ECM_OFF_STAT, 32'h3);
      rises(k ? 15 : 3);
      rdc(`ECM_OFF_STAT, 32'h0, "presc early");
      rises(1);
      rdc(`ECM_OFF_STAT, 32'h1, "presc hit");
    end
    // pwm holds off until a period starts
    wr(`ECM_OFF_CTRL, 32'h0);
    wr(`ECM_OFF_CTRL, 32'h4c);
    mod_lvl <= 1'b1;
    tick(4);
    `CHK("unarmed", 8'hf0, pin)
    for (int b = 0; b < 4; b++)
      for (int p = 0; p < 4; p++)
        for (int m = 0; m < 2; m++)
        begin
          wr(`ECM_OFF_CTRL, {24'h0, b[1:0], 4'h3, p[1:0]});
          mod_lvl <= m[0];
          period <= 1'b1;
          tick(1);
          period <= 1'b0;
          tick(4);
          `CHK("pwm pins", exp_pwm(b[1:0], p[1:0], m[0]), pin)
        end
    // steering picks which single-output pins are driven
    wr(`ECM_OFF_CFG, 32'h50);
    mod_lvl <= 1'b1;
    wr(`ECM_OFF_CTRL, 32'h0c);
    tick(4);
    `CHK("steered pins", 8'h55, pin)
    wr(`ECM_OFF_DUTY, 32'ha5);
    wr(`ECM_OFF_CTRL, 32'h2c);
    tick(2);
    `CHK("duty", 10'h296, duty_value)
    wr(`ECM_OFF_CTRL, 32'h0);
    tick(3);
    `CHK("released", 4'h0, pin[7:4])
    end_of_test();
  end
endmodule // ecm_unit_bench
